// ===== crb_core.sv
/*
 * reset sequencing and bus hold arbitration of the processor local bus.
 * assumes a reset source and a bus master outside; the reset pin and
 * hold request are asynchronous and pass a synchroniser here. bus
 * operations are reported by the execution logic through i_op_*.
 */
// Notes on behaviour
// (RQ1) grant hold only after current operation completes
// (RQ2) coprocessor odd or irq ack: 10+2W
// (RQ3) plain odd-aligned word transfer: 7+2W
// (RQ4) exchange word: even 11+2W, odd 17+4W
// (RQ5) locked string ops: 8+N(4+2W)
// (RQ6) halt during reset, init then fetch
// (RQ7) flags, status word, pointer, selectors reset values
// (RQ8) segment bases, limits, interrupt table reset
// (RQ9) descriptors valid, privilege levels zero
// (RQ10) real mode, first fetch at FFFFF0H
// (RQ11) boot decode ignores top bits until strobe
// (RQ12) source holds reset at least 16 clocks
// (RQ13) at least 50 clocks before first cycle
// (RQ14) ignore interrupts during reset initialization
// (RQ15) source holds reset 5 ms after power-up
// (RQ16) pin levels driven while reset high
// (RQ17) reset mid-cycle ends it, controller reinitialised
// (RQ18) bus controller idle outputs during reset
// (RQ19) commands keep driven; optional multimaster float
// (RQ20) float bus except grant, then raise grant
// (RQ21) requester starts no cycle before grant
// (RQ22) reset and hold request synchronised first
`timescale 1ns/1ps
`default_nettype none
`include "crb_defines.svh"
module crb_core
    import crb_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // asynchronous pins
    input wire logic i_reset_pin,
    input wire logic i_hold_req,
    input wire logic i_irq,
    input wire logic i_nmi,
    // bus operation reported by execution logic
    input wire logic i_op_start,
    input wire crb_pkg::crb_op_e i_op_kind,
    input wire logic [7:0] i_op_count,
    input wire logic i_op_done,
    input wire logic [3:0] i_wait_states,
    input wire logic i_protected_entered_strobe,
    input wire logic i_multimaster_select,
    // processor pins
    output logic [23:0] o_addr,
    output logic o_addr_oe_n,
    output logic o_data_oe_n,
    output logic [1:0] o_bus_status_pair,
    output logic o_coprocessor_ack,
    output logic o_byte_high_enable,
    output logic o_lock,
    output logic o_mem_io_sel,
    output logic o_code_or_irq_ack,
    output logic o_hold_grant,
    output logic o_ready,
    // bus controller idle levels
    output logic o_addr_latch_en,
    output logic o_transceiver_enable,
    output logic o_transceiver_direction,
    output logic o_cascade_enable,
    output logic o_cmd_n,
    output logic o_cmd_oe_n,
    // status
    output logic o_fetch_enable,
    output logic [23:0] o_fetch_addr,
    output logic o_real_mode,
    output logic o_boot_full_decode,
    output logic o_irq_taken,
    output logic o_nmi_taken,
    output logic [15:0] o_flags,
    output logic [15:0] o_machine_status_word,
    output logic [15:0] o_instruction_pointer,
    output logic [15:0] o_cs_sel,
    output logic [23:0] o_cs_base,
    output logic [15:0] o_seg_limit,
    output logic [15:0] o_interrupt_table_limit,
    output logic [23:0] o_interrupt_table_base,
    output logic [3:0] o_seg_valid,
    output logic [7:0] o_seg_priv,
    output logic [15:0] o_hold_latency_bound
);
    // ****************************************
    // synchronisers
    // ****************************************
    logic rst_lvl;
    logic hold_lvl;

    crb_sync u_sync_rst
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_pin(i_reset_pin),
        .o_level(rst_lvl)
    ); // RQ22

    crb_sync u_sync_hold
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_pin(i_hold_req),
        .o_level(hold_lvl)
    ); // RQ22

    // ****************************************
    // sequencer state
    // ****************************************
    crb_state_e state_r;
    crb_state_e state_nxt;
    logic [`CRB_INIT_W-1:0] init_cnt_r;
    logic [`CRB_INIT_W-1:0] init_cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [15:0] lat_r;
    logic [15:0] lat_nxt;
    logic [15:0] lat_now;
    logic [15:0] w2;
    logic full_dec_r;
    logic full_dec_nxt;
    logic irq_r;
    logic irq_nxt;
    logic nmi_r;
    logic nmi_nxt;
    logic grant_r;
    logic grant_nxt;
    logic in_rst;
    logic in_rst_r;
    logic op_end;

    // the reset pin or the synchronous reset both hold the sequencer halted
    assign in_rst = rst_lvl | i_srst;
    assign op_end = busy_r & i_op_done;
    assign w2 = {11'h0, i_wait_states, 1'b0};

    // worst case grant delay of the operation being started
    always_comb
    begin
        lat_now = 16'h0;
        case (i_op_kind)
            CRB_OP_ODD: lat_now = 16'(`CRB_LAT_ODD) + w2; // RQ3
            CRB_OP_COPRO: lat_now = 16'(`CRB_LAT_COPRO) + w2; // RQ2
            CRB_OP_IRQ: lat_now = 16'(`CRB_LAT_IRQ) + w2; // RQ2
            CRB_OP_XCH_EVEN: lat_now = 16'(`CRB_LAT_XCH_EVEN) + w2; // RQ4
            CRB_OP_XCH_ODD: lat_now = 16'(`CRB_LAT_XCH_ODD) + {w2[14:0], 1'b0}; // RQ4
            CRB_OP_STRING: lat_now = 16'(`CRB_LAT_STR_BASE)
                + 16'({8'h0, i_op_count} * (16'(`CRB_LAT_STR_PER) + w2)); // RQ5
            default: lat_now = 16'h0;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        init_cnt_nxt = init_cnt_r;
        busy_nxt = busy_r;
        lat_nxt = lat_r;
        full_dec_nxt = full_dec_r;
        irq_nxt = 1'b0;
        nmi_nxt = 1'b0;
        grant_nxt = 1'b0;
        case (state_r)
            CRB_RESET:
            begin
                busy_nxt = 1'b0; // RQ17
                full_dec_nxt = 1'b0; // RQ11
                init_cnt_nxt = '0;
                if (!in_rst)
                begin
                    state_nxt = CRB_INIT; // RQ6
                end
            end
            CRB_INIT:
            begin
                init_cnt_nxt = init_cnt_r + 1'b1;
                if (init_cnt_r == `CRB_INIT_W'(`CRB_INIT_CLKS - 1))
                begin
                    state_nxt = CRB_RUN; // RQ13
                end
            end
            CRB_RUN:
            begin
                irq_nxt = i_irq;
                nmi_nxt = i_nmi;
                if (i_protected_entered_strobe)
                begin
                    full_dec_nxt = 1'b1;
                end
                if (busy_r)
                begin
                    if (i_op_done)
                    begin
                        busy_nxt = 1'b0;
                    end
                end
                else if (i_op_start && !hold_lvl)
                begin
                    busy_nxt = 1'b1;
                    lat_nxt = lat_now;
                end
                // a new operation is not started while a request waits
                if (hold_lvl && (!busy_r || op_end))
                begin
                    state_nxt = CRB_HOLD; // RQ1
                end
            end
            CRB_HOLD:
            begin
                grant_nxt = hold_lvl; // RQ20
                if (!hold_lvl)
                begin
                    state_nxt = CRB_RUN;
                end
            end
            default:
            begin
                state_nxt = CRB_RESET;
            end
        endcase
        if (in_rst)
        begin
            state_nxt = CRB_RESET; // RQ6
            grant_nxt = 1'b0;
            irq_nxt = 1'b0; // RQ14
            nmi_nxt = 1'b0; // RQ14
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            state_r <= CRB_RESET;
            init_cnt_r <= '0;
            busy_r <= 1'b0;
            lat_r <= 16'h0;
            full_dec_r <= 1'b0;
            irq_r <= 1'b0;
            nmi_r <= 1'b0;
            grant_r <= 1'b0;
            in_rst_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            busy_r <= busy_nxt;
            lat_r <= lat_nxt;
            full_dec_r <= full_dec_nxt;
            irq_r <= irq_nxt;
            nmi_r <= nmi_nxt;
            grant_r <= grant_nxt;
            in_rst_r <= in_rst;
        end
    end

    // ****************************************
    // architectural state loaded at reset
    // ****************************************
    logic [15:0] flags_r;
    logic [15:0] msw_r;
    logic [15:0] ip_r;
    logic [15:0] cs_sel_r;
    logic [23:0] cs_base_r;
    logic [3:0] valid_r;
    logic [7:0] priv_r;

    // held at reset values until execution logic exists beyond this block
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst || in_rst)
        begin
            flags_r <= `CRB_FLAGS_RST; // RQ7
            msw_r <= `CRB_MSW_RST; // RQ7
            ip_r <= `CRB_IP_RST; // RQ7
            cs_sel_r <= `CRB_CS_SEL_RST; // RQ7
            cs_base_r <= `CRB_CS_BASE_RST; // RQ8
            valid_r <= 4'hf; // RQ9
            priv_r <= 8'h00; // RQ9
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    logic drive;
    logic floating;

    assign floating = (state_nxt == CRB_HOLD) || (grant_r && (state_r == CRB_HOLD) && !in_rst); // RQ20
    assign drive = !in_rst && !floating;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_addr <= `CRB_ADDR_RST;
            o_addr_oe_n <= 1'b0;
            o_data_oe_n <= 1'b1;
            o_bus_status_pair <= `CRB_STATUS_IDLE;
            o_coprocessor_ack <= 1'b1;
            o_byte_high_enable <= 1'b1;
            o_lock <= 1'b1;
            o_mem_io_sel <= 1'b0;
            o_code_or_irq_ack <= 1'b0;
            o_ready <= 1'b1;
            o_cmd_oe_n <= 1'b0;
            o_fetch_enable <= 1'b0;
        end
        else
        begin
            // while reset is high the pins hold their reset levels
            o_addr <= in_rst ? `CRB_ADDR_RST : (cs_base_r + {8'h00, ip_r}); // RQ16
            o_addr_oe_n <= floating || (in_rst && i_multimaster_select); // RQ19
            o_data_oe_n <= 1'b1; // RQ16
            o_bus_status_pair <= `CRB_STATUS_IDLE; // RQ16
            o_coprocessor_ack <= 1'b1;
            o_byte_high_enable <= 1'b1;
            o_lock <= 1'b1;
            o_mem_io_sel <= drive ? 1'b1 : 1'b0; // RQ16
            o_code_or_irq_ack <= drive ? 1'b1 : 1'b0; // RQ16
            o_ready <= !(in_rst && busy_r); // RQ17
            o_cmd_oe_n <= in_rst && i_multimaster_select; // RQ19
            o_fetch_enable <= (state_nxt == CRB_RUN) && !floating; // RQ13
        end
    end

    // bus controller idle while reset holds the status pair high
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_addr_latch_en <= 1'b0;
            o_transceiver_enable <= 1'b0;
            o_transceiver_direction <= 1'b1;
            o_cascade_enable <= 1'b0;
            o_cmd_n <= 1'b1;
        end
        else
        begin
            o_addr_latch_en <= 1'b0; // RQ18
            o_transceiver_enable <= 1'b0; // RQ18
            o_transceiver_direction <= 1'b1; // RQ18
            o_cascade_enable <= 1'b0; // RQ18
            o_cmd_n <= 1'b1; // RQ19
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_hold_grant <= 1'b0;
            o_fetch_addr <= `CRB_CS_BASE_RST + {8'h00, `CRB_IP_RST};
            o_real_mode <= 1'b1;
            o_boot_full_decode <= 1'b0;
            o_irq_taken <= 1'b0;
            o_nmi_taken <= 1'b0;
            o_hold_latency_bound <= 16'h0;
        end
        else
        begin
            o_hold_grant <= grant_r && (state_r == CRB_HOLD) && !in_rst; // RQ20
            o_fetch_addr <= cs_base_r + {8'h00, ip_r}; // RQ10
            o_real_mode <= 1'b1; // RQ10
            o_boot_full_decode <= full_dec_r; // RQ11
            o_irq_taken <= irq_r;
            o_nmi_taken <= nmi_r;
            o_hold_latency_bound <= lat_r;
        end
    end

    assign o_flags = flags_r;
    assign o_machine_status_word = msw_r;
    assign o_instruction_pointer = ip_r;
    assign o_cs_sel = cs_sel_r;
    assign o_cs_base = cs_base_r;
    assign o_seg_limit = `CRB_LIMIT_RST; // RQ8
    assign o_interrupt_table_limit = `CRB_ITAB_LIMIT_RST; // RQ8
    assign o_interrupt_table_base = `CRB_ITAB_BASE_RST; // RQ8
    assign o_seg_valid = valid_r;
    assign o_seg_priv = priv_r;

    logic unused_ok;
    assign unused_ok = in_rst_r;
endmodule
`default_nettype wire

// ===== crb_core_assertions.sv
/*
 * concurrent checks of the reset and bus hold sequencer, bound to crb_core.
 * assumes a bench that starts bus operations only while hold request is low.
 */
`timescale 1ns/1ps
`default_nettype none
module crb_core_assertions
    import crb_pkg::*;
(
    // clock, reset and inputs
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_reset_pin,
    input wire logic i_hold_req,
    input wire logic i_multimaster_select,
    input wire logic i_op_start,
    input wire crb_pkg::crb_op_e i_op_kind,
    input wire logic i_op_done,
    input wire logic [3:0] i_wait_states,
    // watched outputs
    input wire logic [23:0] o_addr,
    input wire logic o_addr_oe_n,
    input wire logic o_data_oe_n,
    input wire logic [1:0] o_bus_status_pair,
    input wire logic o_coprocessor_ack,
    input wire logic o_byte_high_enable,
    input wire logic o_lock,
    input wire logic o_mem_io_sel,
    input wire logic o_code_or_irq_ack,
    input wire logic o_hold_grant,
    input wire logic o_ready,
    input wire logic o_addr_latch_en,
    input wire logic o_transceiver_enable,
    input wire logic o_transceiver_direction,
    input wire logic o_cascade_enable,
    input wire logic o_cmd_n,
    input wire logic o_cmd_oe_n,
    input wire logic o_fetch_enable,
    input wire logic [23:0] o_fetch_addr,
    input wire logic o_real_mode,
    input wire logic o_irq_taken,
    input wire logic o_nmi_taken,
    input wire logic [15:0] o_hold_latency_bound
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    // mirrors an accepted bus operation; cleared by completion or reset pin
    logic busy_r;
    logic busy_nxt;
    logic [7:0] low_cnt_r;
    logic [7:0] low_cnt_nxt;

    always_comb
    begin
        busy_nxt = busy_r;
        if (i_op_start && o_fetch_enable && !i_hold_req)
            busy_nxt = 1'b1;
        if (i_op_done || i_reset_pin)
            busy_nxt = 1'b0;
        low_cnt_nxt = i_reset_pin ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hff};
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            busy_r <= 1'b0;
            low_cnt_r <= 8'h00;
        end
        else
        begin
            busy_r <= busy_nxt;
            low_cnt_r <= low_cnt_nxt;
        end
    end

    a_idle_levels: assert property (!o_addr_latch_en && !o_transceiver_enable && o_transceiver_direction
        && !o_cascade_enable && o_cmd_n && o_data_oe_n) else $error("bus controller idle levels wrong");
    a_reset_pins: assert property (i_reset_pin [*8] |-> o_addr == 24'hffffff && o_bus_status_pair == 2'h3
        && o_coprocessor_ack && o_byte_high_enable && o_lock && !o_mem_io_sel && !o_code_or_irq_ack
        && !o_hold_grant && !o_fetch_enable) else $error("pin levels during reset wrong");
    a_mm_float: assert property ((i_reset_pin && i_multimaster_select) [*8] |-> o_cmd_oe_n && o_addr_oe_n)
        else $error("commands not floated in reset");
    a_cmd_driven: assert property (!i_reset_pin [*8] |-> !o_cmd_oe_n) else $error("commands not driven");
    a_grant_float: assert property (o_hold_grant |-> o_addr_oe_n) else $error("bus driven under grant");
    a_grant_cause: assert property ($rose(o_hold_grant) |-> $past(i_hold_req, 3) && !busy_r)
        else $error("grant without request or during operation");
    a_grant_latency: assert property (i_op_done && busy_r && i_hold_req && $past(i_hold_req, 4)
        |-> ##[1:6] o_hold_grant) else $error("grant late after completion");
    a_grant_drop: assert property (!i_hold_req [*8] |-> !o_hold_grant) else $error("grant kept");
    a_init_wait: assert property ($rose(o_fetch_enable) |-> low_cnt_r >= 8'h32)
        else $error("fetch before initialisation time");
    a_irq_mask: assert property (!o_fetch_enable [*3] |-> !o_irq_taken && !o_nmi_taken)
        else $error("interrupt taken while not running");
    a_first_fetch: assert property (o_fetch_enable |-> o_fetch_addr == 24'hfffff0 && o_addr == 24'hfffff0
        && o_real_mode && !o_addr_oe_n) else $error("first fetch address wrong");
    a_ready_cut: assert property (busy_r && $rose(i_reset_pin) |-> ##[1:8] !o_ready)
        else $error("ready not cut by reset");
    a_odd_bound: assert property (i_op_start && o_fetch_enable && !i_hold_req && !busy_r
        && i_op_kind == CRB_OP_ODD |-> ##[1:2] o_hold_latency_bound == 16'h7 + {11'h000, i_wait_states, 1'b0})
        else $error("odd word latency bound wrong");
endmodule
`default_nettype wire

// ===== crb_defines.svh
/*
 * reset values, bus idle levels and timing counts of the reset and
 * bus hold sequencer. assumes a 10 MHz system clock.
 */
`ifndef CRB_DEFINES_SVH
`define CRB_DEFINES_SVH

// ****************************************
// reset state of the architectural registers
// ****************************************
`define CRB_FLAGS_RST 16'h0002
`define CRB_MSW_RST 16'hfff0
`define CRB_IP_RST 16'hfff0
`define CRB_CS_SEL_RST 16'hf000
`define CRB_SEL_RST 16'h0000
`define CRB_CS_BASE_RST 24'hff0000
`define CRB_BASE_RST 24'h000000
`define CRB_LIMIT_RST 16'hffff
`define CRB_ITAB_BASE_RST 24'h000000
`define CRB_ITAB_LIMIT_RST 16'hffff

// ****************************************
// timing
// ****************************************
`define CRB_CLK_NS 100
`define CRB_INIT_CLKS 50
`define CRB_INIT_W 6
`define CRB_RST_MIN_CLKS 16
// hold latency terms, in clocks
`define CRB_LAT_ODD 7
`define CRB_LAT_COPRO 10
`define CRB_LAT_IRQ 10
`define CRB_LAT_XCH_EVEN 11
`define CRB_LAT_XCH_ODD 17
`define CRB_LAT_STR_BASE 8
`define CRB_LAT_STR_PER 4
`define CRB_LAT_W 10

// ****************************************
// bus levels during reset and idle
// ****************************************
`define CRB_ADDR_RST 24'hffffff
`define CRB_STATUS_IDLE 2'h3

`endif

// ===== crb_dma_model.sv
/*
 * bus master that borrows the local bus through hold request and grant.
 * assumes grant comes from crb_core; owns the bus i_len cycles per request.
 */
`timescale 1ns/1ps
`default_nettype none
module crb_dma_model
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // bench control
    input wire logic i_go,
    input wire logic [7:0] i_len,
    // processor side
    input wire logic i_hold_grant,
    output logic o_hold_req,
    output logic o_owner
);
    logic [7:0] cnt_r;

    // ownership ends at the edge that drops the request, so the bus is
    // released long before the processor can see the drop and drive again
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_hold_req <= 1'b0;
            o_owner <= 1'b0;
            cnt_r <= 8'h00;
        end
        else if (i_go)
        begin
            o_hold_req <= 1'b1;
            cnt_r <= i_len;
        end
        else if (o_hold_req && i_hold_grant)
        begin
            o_owner <= cnt_r != 8'h00;
            o_hold_req <= cnt_r != 8'h00;
            cnt_r <= cnt_r - {7'h00, cnt_r != 8'h00};
        end
    end
endmodule
`default_nettype wire

// ===== crb_pkg.sv
/*
 * types shared by the reset and bus hold sequencer.
 * assumes crb_defines.svh supplies the numbers.
 */
package crb_pkg;
    typedef enum logic [3:0] {
        CRB_RESET = 4'h1,
        CRB_INIT = 4'h2,
        CRB_RUN = 4'h4,
        CRB_HOLD = 4'h8
    } crb_state_e;

    typedef enum logic [2:0] {
        CRB_OP_PLAIN = 3'h0,
        CRB_OP_ODD = 3'h1,
        CRB_OP_COPRO = 3'h2,
        CRB_OP_IRQ = 3'h3,
        CRB_OP_XCH_EVEN = 3'h4,
        CRB_OP_XCH_ODD = 3'h5,
        CRB_OP_STRING = 3'h6
    } crb_op_e;
endpackage

// ===== crb_sync.sv
/*
 * three-stage synchroniser with agreement filter for one pin.
 * assumes the pin may change at any time relative to i_clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module crb_sync
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // pin and result
    input wire logic i_pin,
    output logic o_level
);
    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic lvl_r;
    logic lvl_nxt;

    always_comb
    begin
        sh_nxt = {sh_r[1:0], i_pin};
        lvl_nxt = lvl_r;
        // stage 0 is only read by stage 1; only settled stages vote
        if (sh_r[1] == sh_r[2])
        begin
            lvl_nxt = sh_r[2];
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            sh_r <= 3'h0;
            lvl_r <= 1'b0;
        end
        else
        begin
            sh_r <= sh_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule
`default_nettype wire

// ===== tb_crb_core.sv
/*
 * self-checking bench of crb_core with a bus master model on the hold pins.
 * assumes 10 MHz clock; random values come from a fixed seed.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_crb_core;
    import crb_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    logic i_reset_pin = 1'b1, i_irq = 1'b0, i_nmi = 1'b0, i_op_start = 1'b0, i_op_done = 1'b0;
    logic i_protected_entered_strobe = 1'b0, i_multimaster_select = 1'b0, i_hold_req;
    crb_op_e i_op_kind = CRB_OP_PLAIN;
    logic [7:0] i_op_count = 8'h00;
    logic [3:0] i_wait_states = 4'h0;
    logic [23:0] o_addr, o_fetch_addr, o_cs_base, o_interrupt_table_base;
    logic [15:0] o_flags, o_machine_status_word, o_instruction_pointer, o_cs_sel, o_seg_limit;
    logic [15:0] o_interrupt_table_limit, o_hold_latency_bound;
    logic [1:0] o_bus_status_pair;
    logic [3:0] o_seg_valid;
    logic [7:0] o_seg_priv, dma_len = 8'h00;
    logic o_addr_oe_n, o_data_oe_n, o_coprocessor_ack, o_byte_high_enable, o_lock, o_mem_io_sel;
    logic o_code_or_irq_ack, o_hold_grant, o_ready, o_addr_latch_en, o_transceiver_enable, o_cmd_oe_n;
    logic o_transceiver_direction, o_cascade_enable, o_cmd_n, o_fetch_enable, o_real_mode;
    logic o_boot_full_decode, o_irq_taken, o_nmi_taken, dma_owner, dma_go = 1'b0, ready_low = 1'b0;
    int errors = 0;
    int comparisons = 0;
    int seed = 10;
    int i;

    crb_core i_dut (.*);
    crb_dma_model i_dma (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_go(dma_go), .i_len(dma_len),
        .i_hold_grant(o_hold_grant), .o_hold_req(i_hold_req), .o_owner(dma_owner));

    initial forever #50 i_clk_sys = ~i_clk_sys;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [15:0] exp_bound(input crb_op_e k, input logic [3:0] w, input logic [7:0] n);
        logic [15:0] w2;
        w2 = {11'h000, w, 1'b0};
        case (k)
            CRB_OP_ODD: exp_bound = 16'h7 + w2;
            CRB_OP_COPRO, CRB_OP_IRQ: exp_bound = 16'ha + w2;
            CRB_OP_XCH_EVEN: exp_bound = 16'hb + w2;
            CRB_OP_XCH_ODD: exp_bound = 16'h11 + w2 + w2;
            CRB_OP_STRING: exp_bound = 16'h8 + {8'h00, n} * (16'h4 + w2);
            default: exp_bound = 16'h0000;
        endcase
    endfunction

    task automatic do_reset(input logic mm);
        int k;
        @(posedge i_clk_sys);
        i_reset_pin <= 1'b1;
        i_multimaster_select <= mm;
        for (k = 0; k < 16; k++)
        begin
            @(posedge i_clk_sys);
            i_irq <= $random(seed);
            i_nmi <= $random(seed);
        end
        @(negedge i_clk_sys);
        check("reset_addr", o_addr, 24'hffffff);
        check("reset_pins", {o_mem_io_sel, o_code_or_irq_ack, o_hold_grant, o_data_oe_n, o_lock}, 5'h03);
        check("reset_float", {o_cmd_oe_n, o_addr_oe_n}, {mm, mm});
        @(posedge i_clk_sys);
        i_reset_pin <= 1'b0;
        for (k = 0; k < 100 && o_fetch_enable !== 1'b1; k++)
            @(negedge i_clk_sys);
        check("init_wait", {k >= 50, o_fetch_enable}, 2'h3);
        check("flags", o_flags, 16'h0002);
        check("status_word", o_machine_status_word, 16'hfff0);
        check("pointer", o_instruction_pointer, 16'hfff0);
        check("cs_sel", o_cs_sel, 16'hf000);
        check("cs_base", o_cs_base, 24'hff0000);
        check("limits", {o_seg_limit, o_interrupt_table_limit}, 32'hffffffff);
        check("table_base", o_interrupt_table_base, 24'h000000);
        check("descriptors", {o_seg_valid, o_seg_priv}, 12'hf00);
        check("fetch_addr", o_fetch_addr, 24'hfffff0);
        check("mode", {o_real_mode, o_boot_full_decode}, 2'h2);
    endtask

    task automatic run_op(input crb_op_e kind, input logic hold);
        logic [3:0] w;
        logic [7:0] n;
        int k;
        w = $random(seed);
        n = $random(seed);
        @(posedge i_clk_sys);
        i_op_kind <= kind;
        {i_wait_states, i_op_count, i_op_start} <= {w, n, 1'b1};
        @(posedge i_clk_sys);
        {i_op_start, dma_go, dma_len} <= {1'b0, hold, n};
        @(posedge i_clk_sys);
        dma_go <= 1'b0;
        repeat (8 + w) @(negedge i_clk_sys);
        check("bound", o_hold_latency_bound, exp_bound(kind, w, n));
        check("grant_busy", o_hold_grant, 1'b0);
        @(posedge i_clk_sys);
        i_op_done <= 1'b1;
        @(posedge i_clk_sys);
        i_op_done <= 1'b0;
        for (k = 0; k < 8 && o_hold_grant !== hold; k++)
            @(negedge i_clk_sys);
        check("grant", o_hold_grant, hold);
        for (k = 0; k < 300 && (i_hold_req || o_hold_grant); k++)
            @(negedge i_clk_sys);
        repeat (4) @(negedge i_clk_sys);
        check("resume", {o_hold_grant, o_fetch_enable}, 2'h1);
    endtask

    always @(negedge i_clk_sys)
    begin
        if (dma_owner)
            check("owner", o_hold_grant, 1'b1);
        if (!i_srst && o_ready === 1'b0)
            ready_low = 1'b1;
    end

    initial
    begin
        repeat (40000) @(posedge i_clk_sys);
        errors++;
        conclude();
    end

    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        do_reset(1'b0);
        check("ready_idle", ready_low, 1'b0);
        @(posedge i_clk_sys);
        {i_irq, i_nmi, i_protected_entered_strobe} <= 3'h7;
        @(posedge i_clk_sys);
        i_protected_entered_strobe <= 1'b0;
        repeat (4) @(negedge i_clk_sys);
        check("irq_run", {o_irq_taken, o_nmi_taken, o_boot_full_decode}, 3'h7);
        @(posedge i_clk_sys);
        {i_irq, i_nmi} <= 2'h0;
        for (i = 0; i < 21; i++)
            run_op(crb_op_e'(3'(i % 7)), i[0]);
        @(posedge i_clk_sys);
        i_op_kind <= CRB_OP_XCH_ODD;
        i_op_start <= 1'b1;
        @(posedge i_clk_sys);
        i_op_start <= 1'b0;
        do_reset(1'b1);
        check("ready_cut", ready_low, 1'b1);
        run_op(CRB_OP_STRING, 1'b1);
        conclude();
    end
endmodule

bind crb_core crb_core_assertions u_chk (.*);
`default_nettype wire
